// *** verilog/dual_adc_pkg.sv ***
// Shared constants for the dual converter digital control and readout block.
package dual_adc_pkg;
  localparam int          RESULT_WIDTH   = 14;
  localparam int          MSB_POS        = 13;
  localparam int          CLK_FREQ_MHZ   = 25;
  localparam int          CONV_HS_NS     = 5200;
  localparam int          CONV_SLEEP_NS  = 10000;
  localparam int          CONV_HS_CYC    = (CONV_HS_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int          CONV_SLEEP_CYC = (CONV_SLEEP_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int          CNT_WIDTH      = 9;
  localparam int          FIFO_DEPTH     = 4;
  localparam logic [13:0] RESULT_RESET   = 14'h0000;
  localparam logic [13:0] SIGN_FLIP      = 14'h2000;
endpackage

// *** verilog/result_fifo.sv ***
// Small flip-flop FIFO holding conversion results until the host reads them.
`timescale 1ns/10ps
`default_nettype none
module result_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys_i,  // System clock.
  input  wire logic             nrst_i,     // Asynchronous reset, active low.
  input  wire logic             clk_en_i,   // Clock enable.
  input  wire logic             flush_i,    // Discard all entries.
  input  wire logic [WIDTH-1:0] in_data_i,  // Write data.
  input  wire logic             in_valid_i, // Write request.
  output logic                  in_ready_o, // Not full.
  output logic      [WIDTH-1:0] out_data_o, // Head entry.
  output logic                  out_valid_o,// Not empty.
  input  wire logic             out_ready_i // Pop head.
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("result_fifo needs a power-of-two depth of at least 2");
    end
  end
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 count;
  } fifo_state_t;
  fifo_state_t st;
  fifo_state_t next_st;
  logic        push;
  logic        pop;
  always_comb begin
    next_st = st;
    pop     = out_ready_i && (st.count != '0);
    push    = in_valid_i && (st.count != (AW+1)'(DEPTH));
    if (flush_i) begin
      next_st.wr    = '0;
      next_st.rd    = '0;
      next_st.count = '0;
    end else begin
      if (push) begin
        next_st.mem[st.wr] = in_data_i;
        next_st.wr         = st.wr + 1'b1;
      end
      if (pop) begin
        next_st.rd = st.rd + 1'b1;
      end
      next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= '0;
    end else if (clk_en_i) begin
      st <= next_st;
    end
  end
  assign in_ready_o  = (st.count != (AW+1)'(DEPTH));
  assign out_valid_o = (st.count != '0);
  assign out_data_o  = st.mem[st.rd];
endmodule
`default_nettype wire

// *** verilog/dual_adc_readout.sv ***
// Digital control and parallel readout of a dual simultaneous-sampling converter.
// Function
// - A falling convert-start edge holds both track/holds and starts both conversions.
// - Pair select caught at the start edge picks pair A when low and pair B when high.
// - The data interface answers only while chip select is low.
// - Read strobe low with chip select low enables the outputs with one result.
// - Busy rises on the start edge and falls when the conversion is done.
// - Results leave on a 14-bit three-state bus, bit 13 the MSB, released when not read.
// - Bipolar variants give twos complement, the unipolar variant straight binary.
// - The first read after a conversion gives input 1, the second input 2.
// - Conversion lasts 5.2 us in high sampling mode and 10 us in auto sleep mode.
`timescale 1ns/10ps
`default_nettype none
module dual_adc_readout #(
  parameter int CONV_HS_CYC    = dual_adc_pkg::CONV_HS_CYC,
  parameter int CONV_SLEEP_CYC = dual_adc_pkg::CONV_SLEEP_CYC
) (
  input  wire logic        clk_sys_i,        // System clock, 25 MHz.
  input  wire logic        nrst_i,           // Asynchronous reset, active low.
  input  wire logic        clk_en_i,         // Freezes all state while low.
  input  wire logic        convert_start_n_i,// Convert start pin, active low.
  input  wire logic        pair_select_i,    // Pair select pin.
  input  wire logic        cs_n_i,           // Chip select pin, active low.
  input  wire logic        rd_n_i,           // Read strobe pin, active low.
  input  wire logic        auto_sleep_i,     // High selects auto sleep mode.
  input  wire logic        unipolar_i,       // High selects straight binary coding.
  input  wire logic [13:0] pair_a_input_1_i, // Digitised sample of pair A input 1.
  input  wire logic [13:0] pair_a_input_2_i, // Digitised sample of pair A input 2.
  input  wire logic [13:0] pair_b_input_1_i, // Digitised sample of pair B input 1.
  input  wire logic [13:0] pair_b_input_2_i, // Digitised sample of pair B input 2.
  output logic             hold_o,           // Track/holds in hold.
  output logic             busy_o,           // Conversion in progress.
  output logic [13:0]      result_bus_o,     // Result bus drive value.
  output logic [13:0]      result_bus_oe_o   // Result bus enables, high while driven.
);
  localparam int CW = dual_adc_pkg::CNT_WIDTH + 1;
  // ---------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------
  // The sequencer spends two cycles queueing results, so a count below two
  // would underflow the down counter.
  initial begin
    if (CONV_HS_CYC < 2 || CONV_SLEEP_CYC < 2) begin
      $error("dual_adc_readout conversion counts must be at least two");
    end
    if (CONV_HS_CYC >= (1 << CW) || CONV_SLEEP_CYC >= (1 << CW)) begin
      $error("dual_adc_readout conversion counts do not fit the counter");
    end
    if (dual_adc_pkg::RESULT_WIDTH != $bits(result_bus_o)) begin
      $error("dual_adc_readout result width does not match the bus");
    end
    if (dual_adc_pkg::MSB_POS != dual_adc_pkg::RESULT_WIDTH - 1) begin
      $error("dual_adc_readout sign bit is not the top bit");
    end
    if (dual_adc_pkg::FIFO_DEPTH < 2) begin
      $error("dual_adc_readout queue cannot hold both results");
    end
  end
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  // IDLE waits for a start edge, CONV counts the conversion down, and LOAD2
  // queues the second result before busy drops. The fourth code is unused.
  typedef enum logic [1:0] {
    IDLE  = 2'b00,
    CONV  = 2'b01,
    LOAD2 = 2'b10
  } phase_t;
  // All state sits in one word so that the clock enable freezes it as a whole.
  typedef struct packed {
    phase_t        phase;
    logic [1:0]    cs_sync;
    logic [1:0]    rd_sync;
    logic [2:0]    cv_sync;
    logic [1:0]    ps_sync;
    logic          pair_b;
    logic [CW-1:0] count;
    logic [13:0]   in1;
    logic [13:0]   in2;
    logic          hold;
    logic          busy;
    logic          reading;
    logic [13:0]   bus;
    logic [13:0]   oe;
  } ctl_state_t;
  ctl_state_t    st;
  ctl_state_t    next_st;
  logic          start_edge;
  logic          read_active;
  logic          read_fall;
  logic          read_end;
  logic [13:0]   push_data;
  logic          push_valid;
  logic          push_ready;
  logic [13:0]   head_data;
  logic          head_valid;
  logic [13:0]   code;
  // ---------------------------------------------------------------
  // Result queue
  // ---------------------------------------------------------------
  // Both results of a conversion wait here so the host may read them at its
  // own pace; a start edge flushes the queue, which also resets the read order.
  result_fifo #(
    .WIDTH (dual_adc_pkg::RESULT_WIDTH),
    .DEPTH (dual_adc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .nrst_i      (nrst_i),
    .clk_en_i    (clk_en_i),
    .flush_i     (start_edge),
    .in_data_i   (push_data),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .out_data_o  (head_data),
    .out_valid_o (head_valid),
    .out_ready_i (read_end)
  );
  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st     = st;
    // -------------------------------------------------------------
    // Pin synchronisers
    // -------------------------------------------------------------
    // Only the second stage of each chain, and the third start stage, is decoded; the first may be metastable.
    next_st.cs_sync = {st.cs_sync[0], cs_n_i};
    next_st.rd_sync = {st.rd_sync[0], rd_n_i};
    next_st.cv_sync = {st.cv_sync[1:0], convert_start_n_i};
    next_st.ps_sync = {st.ps_sync[0], pair_select_i};
    // The third start stage only remembers the last settled level for the edge test.
    start_edge  = st.cv_sync[2] && !st.cv_sync[1];
    // -------------------------------------------------------------
    // Read strobe decode
    // -------------------------------------------------------------
    // A strobe with chip select high is ignored, and neither loads nor pops.
    read_active = !st.cs_sync[1] && !st.rd_sync[1];
    read_fall   = read_active && !st.reading;
    // The queue advances at the end of a read, so a long strobe still sees one word.
    read_end    = st.reading && !read_active && head_valid;
    push_valid  = 1'b0;
    push_data   = st.in1;
    code        = dual_adc_pkg::RESULT_RESET;
    next_st.reading = read_active;
    // -------------------------------------------------------------
    // Conversion sequencer
    // -------------------------------------------------------------
    unique case (st.phase)
      IDLE: begin
      end
      CONV: begin
        if (st.count == '0) begin
          push_valid = 1'b1;
          push_data  = st.in1;
          if (push_ready) begin
            next_st.phase = LOAD2;
          end
        end else begin
          next_st.count = st.count - CW'(1);
        end
      end
      LOAD2: begin
        push_valid = 1'b1;
        push_data  = st.in2;
        if (push_ready) begin
          next_st.phase = IDLE;
          next_st.busy  = 1'b0;
          next_st.hold  = 1'b0;
        end
      end
      default: begin
        // An upset code falls back to idle rather than locking busy high.
        next_st.phase = IDLE;
        next_st.busy  = 1'b0;
        next_st.hold  = 1'b0;
      end
    endcase
    // -------------------------------------------------------------
    // Start edge
    // -------------------------------------------------------------
    // A start edge wins over the end of a running conversion, so no restart is lost.
    if (start_edge) begin
      next_st.phase  = CONV;
      next_st.hold   = 1'b1;
      next_st.busy   = 1'b1;
      next_st.pair_b = st.ps_sync[1];
      next_st.count  = auto_sleep_i ? CW'(CONV_SLEEP_CYC - 2) : CW'(CONV_HS_CYC - 2);
      // Sampling both inputs in the same cycle keeps their relative phase.
      next_st.in1 = st.ps_sync[1] ? pair_b_input_1_i : pair_a_input_1_i;
      next_st.in2 = st.ps_sync[1] ? pair_b_input_2_i : pair_a_input_2_i;
      // The FIFO flush doubles as the read-order reset.
    end
    // -------------------------------------------------------------
    // Read port
    // -------------------------------------------------------------
    // Bipolar codes arrive offset binary; flipping the sign bit gives twos complement.
    code = unipolar_i ? head_data : (head_data ^ dual_adc_pkg::SIGN_FLIP);
    // A read with nothing converted returns the last word; this keeps the bus defined.
    if (read_fall && head_valid) begin
      next_st.bus = code;
    end
    next_st.oe = read_active ? 14'h3FFF : 14'h0000;
  end
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st         <= '0;
      st.phase   <= IDLE;
      // The chip select, read and start chains start at the idle high level so that release shows no false edge.
      st.cs_sync <= 2'h3;
      st.rd_sync <= 2'h3;
      st.cv_sync <= 3'h7;
    end else if (clk_en_i) begin
      st <= next_st;
    end
  end
  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Every output is a state bit, so nothing combinational reaches a pin.
  assign hold_o          = st.hold;
  assign busy_o          = st.busy;
  assign result_bus_o    = st.bus;
  assign result_bus_oe_o = st.oe;
endmodule
`default_nettype wire

// *** tb/dual_adc_host.sv ***
// Host model that drives the converter pins and takes results off the bus.
`timescale 1ns/10ps
`default_nettype none
module dual_adc_host (
  input  wire logic        clk_sys_i,         // System clock.
  input  wire logic        busy_i,            // Converter busy.
  input  wire logic [13:0] bus_i,             // Bus drive value.
  input  wire logic [13:0] oe_i,              // Bus enables.
  output var  logic        convert_start_n_o, // Convert start pin.
  output var  logic        pair_select_o,     // Pair select pin.
  output var  logic        cs_n_o,            // Chip select pin.
  output var  logic        rd_n_o             // Read strobe pin.
);
  // Released bits read as the inverse of the drive value, so stale data never matches.
  wire [13:0] bus_w = (bus_i & oe_i) | (~bus_i & ~oe_i);
  initial begin
    convert_start_n_o = 1'b1;
    pair_select_o = 1'b0;
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
  end
  task automatic convert(input logic sel);
    @(posedge clk_sys_i);
    pair_select_o <= sel;
    // Ten idle cycles keep the last read at least 400 ns clear of the start edge.
    repeat (10) @(posedge clk_sys_i);
    convert_start_n_o <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    convert_start_n_o <= 1'b1;
    @(negedge clk_sys_i);
    for (int n = 0; n < 400 && busy_i !== 1'b0; n++) @(negedge clk_sys_i);
    repeat (12) @(posedge clk_sys_i);
  endtask
  task automatic read(input logic chip, output logic [13:0] d, output logic [13:0] o);
    @(posedge clk_sys_i);
    cs_n_o <= ~chip;
    rd_n_o <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    d = bus_w;
    o = oe_i;
    @(posedge clk_sys_i);
    cs_n_o <= 1'b1;
    rd_n_o <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
  endtask
endmodule
`default_nettype wire

// *** tb/dual_adc_readout_chk.sv ***
// Port-level assertions for the dual converter readout block.
`timescale 1ns/10ps
`default_nettype none
module dual_adc_readout_chk #(
  parameter int CONV_HS_CYC    = 130,
  parameter int CONV_SLEEP_CYC = 250
) (
  input wire logic        clk_sys_i,         // Clock.
  input wire logic        nrst_i,            // Reset.
  input wire logic        clk_en_i,          // Clock enable.
  input wire logic        convert_start_n_i, // Start pin.
  input wire logic        cs_n_i,            // Chip select.
  input wire logic        rd_n_i,            // Read strobe.
  input wire logic        auto_sleep_i,      // Mode.
  input wire logic        hold_o,            // Hold.
  input wire logic        busy_o,            // Busy.
  input wire logic [13:0] result_bus_o,      // Bus value.
  input wire logic [13:0] result_bus_oe_o    // Bus enables.
);
  logic [8:0] busy_len;
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_len <= 9'h000;
    end else if (clk_en_i) begin
      // Frozen cycles are not conversion time, so they are not counted.
      busy_len <= busy_o ? busy_len + 9'h001 : 9'h000;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  sequence start_fall;
    $fell(convert_start_n_i);
  endsequence
  sequence read_held;
    (!cs_n_i && !rd_n_i) [*3];
  endsequence
  start_hold_a: assert property (start_fall |-> ##3 busy_o && hold_o)
    else $error("busy or hold late after start edge");
  busy_cause_a: assert property ($rose(busy_o) |-> !$past(convert_start_n_i, 3))
    else $error("busy rose without a start edge");
  busy_len_a: assert property ($fell(busy_o) |-> (auto_sleep_i ?
    (busy_len >= CONV_SLEEP_CYC - 1 && busy_len <= CONV_SLEEP_CYC) :
    (busy_len >= CONV_HS_CYC - 1 && busy_len <= CONV_HS_CYC))) else $error("busy length wrong");
  read_oe_a: assert property (read_held |=> result_bus_oe_o == 14'h3FFF)
    else $error("bus not driven during read");
  idle_oe_a: assert property ((cs_n_i || rd_n_i) [*3] |=> result_bus_oe_o == 14'h0000)
    else $error("bus driven while not read");
  cs_gate_a: assert property (result_bus_oe_o != 14'h0000 |->
    !$past(cs_n_i, 3) && !$past(rd_n_i, 3)) else $error("bus driven without select");
  oe_whole_a: assert property (result_bus_oe_o == 14'h0000 || result_bus_oe_o == 14'h3FFF)
    else $error("bus partly driven");
  bus_steady_a: assert property ($past(result_bus_oe_o) == 14'h3FFF &&
    result_bus_oe_o == 14'h3FFF |-> $stable(result_bus_o)) else $error("bus changed in read");
endmodule
bind dual_adc_readout dual_adc_readout_chk #(
  .CONV_HS_CYC(CONV_HS_CYC),
  .CONV_SLEEP_CYC(CONV_SLEEP_CYC)
) chk (.clk_sys_i, .nrst_i, .clk_en_i, .convert_start_n_i, .cs_n_i, .rd_n_i, .auto_sleep_i,
  .hold_o, .busy_o, .result_bus_o, .result_bus_oe_o);
`default_nettype wire

// *** tb/dual_adc_readout_tb_top.sv ***
// Self-checking testbench for the dual converter readout block.
`timescale 1ns/10ps
`default_nettype none
module dual_adc_readout_tb_top;
  logic        clk_sys_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        auto_sleep = 1'b0;
  logic        unipolar = 1'b0;
  logic        clk_en = 1'b1;
  logic [13:0] in_a1 = 14'h0000, in_a2 = 14'h0000, in_b1 = 14'h0000, in_b2 = 14'h0000;
  wire         busy, hold, conv_n, sel, cs_n, rd_n;
  wire  [13:0] bus, oe;
  int          bad_count = 0;
  int          compares = 0;
  dual_adc_readout #(.CONV_HS_CYC(4), .CONV_SLEEP_CYC(8)) dut (.clk_sys_i, .nrst_i,
    .clk_en_i(clk_en), .convert_start_n_i(conv_n), .pair_select_i(sel), .cs_n_i(cs_n),
    .rd_n_i(rd_n), .auto_sleep_i(auto_sleep), .unipolar_i(unipolar), .pair_a_input_1_i(in_a1),
    .pair_a_input_2_i(in_a2), .pair_b_input_1_i(in_b1), .pair_b_input_2_i(in_b2),
    .hold_o(hold), .busy_o(busy), .result_bus_o(bus), .result_bus_oe_o(oe));
  dual_adc_host host (.clk_sys_i, .busy_i(busy), .bus_i(bus), .oe_i(oe),
    .convert_start_n_o(conv_n), .pair_select_o(sel), .cs_n_o(cs_n), .rd_n_o(rd_n));
  initial begin
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic set_codes(input logic [13:0] base);
    @(posedge clk_sys_i);
    in_a1 <= base;
    in_a2 <= ~base;
    in_b1 <= base ^ 14'h1555;
    in_b2 <= base ^ 14'h2AAA;
  endtask
  // Bipolar samples arrive offset binary, so twos complement is the sign bit flipped.
  task automatic read_chk(input logic s, input logic second);
    logic [13:0] d, o, raw;
    raw = s ? (second ? in_b2 : in_b1) : (second ? in_a2 : in_a1);
    host.read(1'b1, d, o);
    chk(o, 14'h3FFF);
    chk(d, unipolar ? raw : raw ^ dual_adc_pkg::SIGN_FLIP);
  endtask
  task automatic t_pairs();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys_i);
      unipolar <= i[1];
      auto_sleep <= i[0] ^ i[1];
      set_codes(14'(i) * 14'h0913 + 14'h00C5);
      host.convert(i[0]);
      chk_bit(busy, 1'b0);
      chk_bit(hold, 1'b0);
      read_chk(i[0], 1'b0);
      read_chk(i[0], 1'b1);
    end
  endtask
  task automatic t_no_select();
    logic [13:0] d, o;
    set_codes(14'h2468);
    host.convert(1'b0);
    host.read(1'b0, d, o);
    chk(o, 14'h0000);
    read_chk(1'b0, 1'b0);
    read_chk(1'b0, 1'b1);
    read_chk(1'b0, 1'b1);
  endtask
  task automatic t_restart_order();
    set_codes(14'h1E0F);
    host.convert(1'b1);
    read_chk(1'b1, 1'b0);
    set_codes(14'h3333);
    host.convert(1'b1);
    read_chk(1'b1, 1'b0);
    read_chk(1'b1, 1'b1);
  endtask
  // Ten frozen cycles inside a conversion must keep busy and hold high and leave both results readable.
  task automatic t_freeze();
    set_codes(14'h1357);
    fork
      host.convert(1'b1);
      begin
        wait (busy === 1'b1);
        @(posedge clk_sys_i);
        clk_en <= 1'b0;
        repeat (10) @(posedge clk_sys_i);
        chk_bit(busy, 1'b1);
        chk_bit(hold, 1'b1);
        clk_en <= 1'b1;
      end
    join
    chk_bit(busy, 1'b0);
    read_chk(1'b1, 1'b0);
    read_chk(1'b1, 1'b1);
  endtask
  // A reset in mid conversion clears every output, and the next conversion starts clean.
  task automatic t_mid_reset();
    set_codes(14'h0ABC);
    fork
      host.convert(1'b0);
      begin
        wait (busy === 1'b1);
        @(posedge clk_sys_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        chk_bit(busy, 1'b0);
        chk_bit(hold, 1'b0);
        chk(oe, 14'h0000);
        chk(bus, dual_adc_pkg::RESULT_RESET);
        nrst_i <= 1'b1;
      end
    join
    set_codes(14'h0DEF);
    host.convert(1'b0);
    chk_bit(busy, 1'b0);
    read_chk(1'b0, 1'b0);
    read_chk(1'b0, 1'b1);
  endtask
  task automatic final_report();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    t_pairs();
    t_no_select();
    t_restart_order();
    t_freeze();
    t_mid_reset();
    final_report();
  end
  initial begin
    repeat (4000) @(posedge clk_sys_i);
    bad_count++;
    final_report();
  end
endmodule
`default_nettype wire
